// ===== design/sdram_mode_config_mpr.sv
// Mode register decode, additive latency hold and calibration pattern readout
`timescale 1ns/1ps
// How it works
// - Impedance taken from first register A1, A5
// - Write termination applies even without nominal
// - Reads/writes held for additive latency
// - Latencies are AL plus CL or CAS_WRITE_LATENCY
// - AL code: 00 zero, 01 CL-1, 10 CL-2
// - Output disable bit floats data and strobes
// - CAS_WRITE_LATENCY from second register bits A3-A5
// - Dynamic termination from A9, A10
// - Write leveling uses nominal termination only
// - Readout mode redirects reads, drops auto-precharge
// - Readout off: array access, location ignored
// - Lane bit zero carries data, rest copy/zero
// - Burst order 0-7, or nibble by A2
// - On-the-fly chop honoured when enabled
// - Location zero gives 0,1,0,1 pattern
// - Beat zero is LSB, beat seven MSB
module sdram_mode_config_mpr #(
  parameter int AL_DEPTH = 16, // Delay line depth; longest additive latency held is one less
  parameter int LANES = 2, // Byte lanes on the data bus
  parameter bit FILL_COPY = 1'b1 // Upper lane bits copy bit zero when set
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [2:0] bankAddr,
  input wire logic [15:0] addrBus,
  input wire logic [4:0] casLatency,
  input wire sdram_mode_pkg::burst_mode_t burstMode,
  input wire logic writeActive,
  output sdram_mode_pkg::mode_cfg_t modeCfg,
  output logic [4:0] additiveLatency,
  output logic [4:0] casWriteLatency,
  output logic [4:0] readLatency,
  output logic [4:0] writeLatency,
  output sdram_mode_pkg::term_t termApplied,
  output sdram_mode_pkg::cmd_t internalCmd,
  output logic [8*LANES-1:0] dqOut,
  output logic dqOeN,
  output logic dqsOeN,
  output logic mprBusy
);

  // Idle waits for a redirected read, wait counts off the CAS latency,
  // burst puts one beat per clock on the lanes. One beat per clock keeps
  // the model single-rate; the real lanes move two beats per clock.
  // Readout engine states
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_BURST} rd_state_t;

  logic ckePrev; // Clock enable from the previous edge
  logic modeSet; // Mode register set decoded this cycle
  logic colCmd; // Read or write decoded this cycle
  logic chopNow; // Burst chop for the incoming column command
  sdram_mode_pkg::cmd_t incoming; // Column command as taken from the pins
  sdram_mode_pkg::cmd_t holdLine [AL_DEPTH]; // Additive latency delay line
  sdram_mode_pkg::cmd_t selected; // Delay line tap for the current latency
  logic [4:0] tap; // Tap index, clamped to the line depth
  rd_state_t rdState; // Readout engine state
  logic [4:0] waitCnt; // Cycles left before the first beat
  logic [3:0] beatsLeft; // Beats still to drive
  logic [2:0] beatIdx; // Burst position of the next beat
  logic [7:0] locData; // Pattern of the selected location
  logic driving; // Engine is putting beats on the bus

  // Command decode, sampled on every rising edge
  // Previous clock enable tells power-down exit from steady operation
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ckePrev <= 1'b0;
    end else begin
      ckePrev <= cke;
    end
  end

  // Both decodes need clock enable high on this and the previous edge,
  // so a command on the first edge after reset is ignored.
  // Refresh, precharge and activate decode to neither and pass unseen.
  assign modeSet = ckePrev && cke && !csN && !rasN && !casN && !weN;
  assign colCmd = ckePrev && cke && !csN && rasN && !casN;

  // Chop follows A12 only when on-the-fly selection is enabled
  always_comb begin
    unique case (burstMode)
      sdram_mode_pkg::BURST_ON_FLY: chopNow = !addrBus[sdram_mode_pkg::A_CHOP];
      sdram_mode_pkg::BURST_FIXED4: chopNow = 1'b1;
      // Fixed eight and the unused code both give full bursts
      default: chopNow = 1'b0;
    endcase
  end

  // Mode register writes; each register changes only on its own select
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      modeCfg <= '0;
    end else if (modeSet) begin
      // Bank address picks the register; address bits carry the fields
      // Bits with no field here are dropped, the lock-loop and test bits too
      unique case (bankAddr)
        sdram_mode_pkg::BA_FIRST: begin
          modeCfg.driverImpedance <= {addrBus[sdram_mode_pkg::FM_IMP_HI],
                                      addrBus[sdram_mode_pkg::FM_IMP_LO]};
          modeCfg.nominalTerm <= {addrBus[sdram_mode_pkg::FM_NOM_B2],
                                  addrBus[sdram_mode_pkg::FM_NOM_B1],
                                  addrBus[sdram_mode_pkg::FM_NOM_B0]};
          modeCfg.alCode <= addrBus[sdram_mode_pkg::FM_AL_HI:sdram_mode_pkg::FM_AL_LO];
          modeCfg.writeLeveling <= addrBus[sdram_mode_pkg::FM_WLEVEL];
          modeCfg.outputsOff <= addrBus[sdram_mode_pkg::FM_QOFF];
        end
        sdram_mode_pkg::BA_SECOND: begin
          modeCfg.cwlCode <= addrBus[sdram_mode_pkg::SM_CWL_HI:sdram_mode_pkg::SM_CWL_LO];
          modeCfg.autoSelfRefresh <= addrBus[sdram_mode_pkg::SM_ASR];
          modeCfg.selfRefreshTemp <= addrBus[sdram_mode_pkg::SM_SRT];
          modeCfg.writeTerm <= addrBus[sdram_mode_pkg::SM_WRT_HI:sdram_mode_pkg::SM_WRT_LO];
        end
        sdram_mode_pkg::BA_THIRD: begin
          modeCfg.mprEnable <= addrBus[sdram_mode_pkg::TM_MPR];
          modeCfg.mprLocation <= addrBus[sdram_mode_pkg::TM_LOC_HI:sdram_mode_pkg::TM_LOC_LO];
        end
        // Zeroth register and unused selects leave all fields alone
        default: begin
        end
      endcase
    end
  end

  // CAS latency below two would wrap; the controller keeps it at five or more
  // Additive latency decode; reserved code behaves as disabled
  always_comb begin
    unique case (modeCfg.alCode)
      sdram_mode_pkg::AL_CL1: additiveLatency = casLatency - sdram_mode_pkg::ONE_CYCLE;
      sdram_mode_pkg::AL_CL2: additiveLatency = casLatency - sdram_mode_pkg::TWO_CYCLES;
      default: additiveLatency = 5'h00;
    endcase
  end

  // Whole-cycle latencies, no half clocks
  // Write latency code zero means five cycles; larger codes are not range checked
  // Five-bit sums; the largest supported latencies still fit
  assign casWriteLatency = sdram_mode_pkg::CWL_BASE + {2'h0, modeCfg.cwlCode};
  assign readLatency = additiveLatency + casLatency;
  assign writeLatency = additiveLatency + casWriteLatency;

  // Termination select; write value wins during writes unless leveling
  // Registered so the termination control changes once per clock, glitch free
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      termApplied <= '0;
    end else if (modeCfg.writeLeveling) begin
      termApplied <= '{useWriteValue: 1'b0, code: modeCfg.nominalTerm};
    end else if (writeActive && modeCfg.writeTerm != 2'h0) begin
      // Applies regardless of the nominal setting being off
      termApplied <= '{useWriteValue: 1'b1, code: {1'b0, modeCfg.writeTerm}};
    end else begin
      termApplied <= '{useWriteValue: 1'b0, code: modeCfg.nominalTerm};
    end
  end

  // Incoming command with readout redirect decided at the pins
  // Deciding at entry means a later mode set cannot re-route a held read;
  // the controller sends nothing but reads during readout anyway.
  // Writes are never redirected, whatever the readout setting.
  always_comb begin
    incoming.valid = colCmd;
    incoming.isRead = weN;
    incoming.toMpr = weN && modeCfg.mprEnable;
    incoming.autoPre = addrBus[sdram_mode_pkg::A_AUTOPRE] && !(weN && modeCfg.mprEnable);
    incoming.chop = chopNow;
    incoming.bank = bankAddr;
    incoming.addr = addrBus;
  end

  // Delay line head; accepts a command on any cycle, even right after activate
  // Idle cycles enter too; only the valid bit marks a real command
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      holdLine[0] <= '0;
    end else begin
      holdLine[0] <= incoming;
    end
  end

  // Remaining delay line stages, one per cycle of latency
  // Every stage resets, so nothing stale issues after a mid-run reset
  for (genvar s = 1; s < AL_DEPTH; s++) begin : g_hold
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        holdLine[s] <= '0;
      end else begin
        holdLine[s] <= holdLine[s-1];
      end
    end
  end

  // Latency beyond the line depth is clamped; keep AL_DEPTH above any AL used
  // Tap zero still costs the fixed pipeline; every latency shifts alike
  assign tap = (additiveLatency >= 5'(AL_DEPTH)) ? 5'(AL_DEPTH - 1) : additiveLatency;
  assign selected = holdLine[tap[$clog2(AL_DEPTH)-1:0]];

  // Internal issue after the held latency
  // Issued from a flop, not straight from the tap multiplexer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      internalCmd <= '0;
    end else begin
      internalCmd <= selected;
    end
  end

  // Location pattern; reserved locations read as zero
  // Reserved places are undefined; zero keeps the lanes quiet
  assign locData = (modeCfg.mprLocation == sdram_mode_pkg::LOC_PATTERN) ?
                   sdram_mode_pkg::CAL_PATTERN : sdram_mode_pkg::RFU_PATTERN;

  // Readout engine; a read arriving while busy is dropped, not queued
  // The wait count starts at CAS latency minus one, since the move out
  // of idle already spends one clock of that latency.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdState <= RD_IDLE;
      waitCnt <= 5'h00;
      beatsLeft <= 4'h0;
      beatIdx <= 3'h0;
      driving <= 1'b0;
      dqOut <= '0;
    end else begin
      unique case (rdState)
        RD_IDLE: begin
          // Array reads leave here; only redirected reads start the engine
          // Chop and start nibble are frozen here for the whole burst
          if (internalCmd.valid && internalCmd.toMpr) begin
            rdState <= RD_WAIT;
            waitCnt <= casLatency - sdram_mode_pkg::ONE_CYCLE;
            // Nibble choice only under chop; full bursts always start at zero
            beatIdx <= (internalCmd.chop && internalCmd.addr[sdram_mode_pkg::A_NIBBLE]) ?
                       sdram_mode_pkg::UPPER_NIBBLE : 3'h0;
            beatsLeft <= internalCmd.chop ? sdram_mode_pkg::BEATS_FOUR :
                         sdram_mode_pkg::BEATS_EIGHT;
          end
        end
        RD_WAIT: begin
          // First beat leaves on the clock at which the count reaches one
          waitCnt <= waitCnt - sdram_mode_pkg::ONE_CYCLE;
          if (waitCnt == sdram_mode_pkg::ONE_CYCLE) begin
            rdState <= RD_BURST;
            driving <= 1'b1;
            dqOut <= laneWord(locData[beatIdx]);
            beatIdx <= beatIdx + 3'h1;
            beatsLeft <= beatsLeft - 4'h1;
          end
        end
        RD_BURST: begin
          // Last beat went out on the previous clock; release the bus
          if (beatsLeft == 4'h0) begin
            rdState <= RD_IDLE;
            driving <= 1'b0;
            dqOut <= '0;
          end else begin
            dqOut <= laneWord(locData[beatIdx]);
            beatIdx <= beatIdx + 3'h1;
            beatsLeft <= beatsLeft - 4'h1;
          end
        end
        // Unused state code: recover to idle with the bus released
        default: begin
          rdState <= RD_IDLE;
          driving <= 1'b0;
        end
      endcase
    end
  end

  // Fill every lane: bit zero carries the beat, upper bits copy or zero
  // Copies give a stronger calibration edge, zeros less switching noise;
  // the choice is a parameter because both fills are allowed.
  function automatic logic [8*LANES-1:0] laneWord(input logic beat);
    logic [8*LANES-1:0] word;
    word = '0;
    for (int l = 0; l < LANES; l++) begin
      word[8*l] = beat;
      for (int b = 1; b < 8; b++) begin
        word[8*l+b] = FILL_COPY ? beat : 1'b0;
      end
    end
    return word;
  endfunction : laneWord

  // Output disable overrides the engine; enables are active low
  // The engine keeps counting while off, so timing is unchanged on return
  assign dqOeN = !driving || modeCfg.outputsOff;
  assign dqsOeN = !driving || modeCfg.outputsOff;
  // Busy covers the wait as well, so a second read is dropped early
  assign mprBusy = (rdState != RD_IDLE);

endmodule : sdram_mode_config_mpr

// ===== design/sdram_mode_pkg.sv
// Shared constants and carrier types for the mode decode and calibration readout block
package sdram_mode_pkg;

  // Bank address values that select the first, second and third mode registers on a mode set
  localparam logic [2:0] BA_FIRST = 3'h1;
  localparam logic [2:0] BA_SECOND = 3'h2;
  localparam logic [2:0] BA_THIRD = 3'h3;

  // First mode register field positions
  localparam int FM_IMP_LO = 1;
  localparam int FM_IMP_HI = 5;
  localparam int FM_NOM_B0 = 2;
  localparam int FM_NOM_B1 = 6;
  localparam int FM_NOM_B2 = 9;
  localparam int FM_AL_LO = 3;
  localparam int FM_AL_HI = 4;
  localparam int FM_WLEVEL = 7;
  localparam int FM_QOFF = 12;

  // Second mode register field positions
  localparam int SM_CWL_LO = 3;
  localparam int SM_CWL_HI = 5;
  localparam int SM_ASR = 6;
  localparam int SM_SRT = 7;
  localparam int SM_WRT_LO = 9;
  localparam int SM_WRT_HI = 10;

  // Third mode register field positions
  localparam int TM_LOC_LO = 0;
  localparam int TM_LOC_HI = 1;
  localparam int TM_MPR = 2;

  // Column address bits used by reads and writes
  localparam int A_NIBBLE = 2;
  localparam int A_AUTOPRE = 10;
  localparam int A_CHOP = 12;

  // Additive latency codes
  localparam logic [1:0] AL_OFF = 2'h0;
  localparam logic [1:0] AL_CL1 = 2'h1;
  localparam logic [1:0] AL_CL2 = 2'h2;

  // Latency arithmetic
  localparam logic [4:0] CWL_BASE = 5'h05;
  localparam logic [4:0] ONE_CYCLE = 5'h01;
  localparam logic [4:0] TWO_CYCLES = 5'h02;

  // Calibration readout constants
  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [7:0] CAL_PATTERN = 8'hAA;
  localparam logic [7:0] RFU_PATTERN = 8'h00;
  localparam logic [3:0] BEATS_EIGHT = 4'h8;
  localparam logic [3:0] BEATS_FOUR = 4'h4;
  localparam logic [2:0] UPPER_NIBBLE = 3'h4;

  // Burst length selection from the zeroth mode register
  typedef enum logic [1:0] {BURST_FIXED8, BURST_ON_FLY, BURST_FIXED4} burst_mode_t;

  // Command as held through the additive latency
  typedef struct packed {
    logic valid;
    logic isRead;
    logic toMpr;
    logic autoPre;
    logic chop;
    logic [2:0] bank;
    logic [15:0] addr;
  } cmd_t;

  // Decoded mode settings
  typedef struct packed {
    logic [1:0] driverImpedance;
    logic [2:0] nominalTerm;
    logic [1:0] alCode;
    logic writeLeveling;
    logic outputsOff;
    logic [2:0] cwlCode;
    logic autoSelfRefresh;
    logic selfRefreshTemp;
    logic [1:0] writeTerm;
    logic mprEnable;
    logic [1:0] mprLocation;
  } mode_cfg_t;

  // Termination actually applied
  typedef struct packed {
    logic useWriteValue;
    logic [2:0] code;
  } term_t;

endpackage : sdram_mode_pkg

// ===== tb/sdram_ctrl_model.sv
// Controller side model driving the command bus
`timescale 1ns/1ps
module sdram_ctrl_model (
  input wire logic clk,
  output logic cke,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [2:0] bankAddr,
  output logic [15:0] addrBus
);
  // Idle bus, clock enable high from the start
  initial begin
    cke = 1'b1;
    {csN, rasN, casN, weN} = 4'hF;
    bankAddr = 3'h0;
    addrBus = 16'h0000;
  end
  // Launch point just after each rising edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  // One command cycle, then deselect with stale values turned over
  task automatic send(input logic [2:0] rcw, input logic [2:0] ba, input logic [15:0] a);
    tick();
    {csN, rasN, casN, weN} = {1'b0, rcw};
    bankAddr = ba;
    addrBus = a;
    tick();
    csN = 1'b1;
    bankAddr = ~ba;
    addrBus = ~a;
  endtask : send
endmodule : sdram_ctrl_model

// ===== tb/sdram_mode_config_mpr_properties.sv
// Port checks for the mode decode and readout block
`timescale 1ns/1ps
module sdram_mode_config_mpr_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [2:0] bankAddr,
  input wire logic [15:0] addrBus,
  input wire logic [4:0] casLatency,
  input wire logic writeActive,
  input wire sdram_mode_pkg::mode_cfg_t modeCfg,
  input wire logic [4:0] additiveLatency,
  input wire logic [4:0] casWriteLatency,
  input wire logic [4:0] readLatency,
  input wire logic [4:0] writeLatency,
  input wire sdram_mode_pkg::term_t termApplied,
  input wire sdram_mode_pkg::cmd_t internalCmd,
  input wire logic dqOeN,
  input wire logic dqsOeN
);
  logic ckePrev; // Cleared by reset, as in the block
  logic [15:0] addrQ; // Address one edge back
  logic modeSet; // Mode set taken at this edge
  // Helpers so no assertion needs a deep history
  always_ff @(posedge clk) begin
    ckePrev <= sys_rst ? 1'b0 : cke;
    addrQ <= addrBus;
  end
  assign modeSet = ckePrev && cke && !csN && !rasN && !casN && !weN;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_impedance_decode: assert property (
    modeSet && bankAddr == 3'h1 |=> modeCfg.driverImpedance == {addrQ[5], addrQ[1]})
    else $error("impedance decode wrong");
  a_al_decode: assert property (additiveLatency == (modeCfg.alCode == 2'h1 ?
    casLatency - 5'h01 : modeCfg.alCode == 2'h2 ? casLatency - 5'h02 : 5'h00))
    else $error("additive latency wrong");
  a_latency_sums: assert property (readLatency == additiveLatency + casLatency &&
    writeLatency == additiveLatency + casWriteLatency &&
    casWriteLatency == sdram_mode_pkg::CWL_BASE + 5'(modeCfg.cwlCode)) else $error("latency sum");
  a_output_off: assert property (modeCfg.outputsOff |-> dqOeN && dqsOeN)
    else $error("outputs driven while off");
  a_write_term: assert property (
    writeActive && !modeCfg.writeLeveling && modeCfg.writeTerm != 2'h0 && !modeSet |=>
    termApplied.useWriteValue && termApplied.code == {1'b0, modeCfg.writeTerm})
    else $error("write termination missing");
  a_level_nominal: assert property (
    modeCfg.writeLeveling && !modeSet |=> !termApplied.useWriteValue)
    else $error("write termination in leveling");
  a_field_hold: assert property (!modeSet |=> $stable(modeCfg))
    else $error("mode field changed");
  a_mpr_redirect: assert property (
    internalCmd.valid && internalCmd.isRead && modeCfg.mprEnable |->
    internalCmd.toMpr && !internalCmd.autoPre) else $error("read not redirected");
  a_array_access: assert property (
    internalCmd.valid && !(modeCfg.mprEnable && internalCmd.isRead) |-> !internalCmd.toMpr)
    else $error("access wrongly redirected");
  a_burst_min: assert property ($fell(dqOeN) |-> !dqOeN [*4])
    else $error("burst shorter than four");
endmodule : sdram_mode_config_mpr_properties
bind sdram_mode_config_mpr sdram_mode_config_mpr_properties props (
  .clk(clk), .sys_rst(sys_rst), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
  .bankAddr(bankAddr), .addrBus(addrBus), .casLatency(casLatency), .writeActive(writeActive),
  .modeCfg(modeCfg), .additiveLatency(additiveLatency), .casWriteLatency(casWriteLatency),
  .readLatency(readLatency), .writeLatency(writeLatency), .termApplied(termApplied),
  .internalCmd(internalCmd), .dqOeN(dqOeN), .dqsOeN(dqsOeN));

// ===== tb/sdram_mode_config_mpr_tb.sv
// Self-checking bench for the mode decode and readout block
`timescale 1ns/1ps
module sdram_mode_config_mpr_tb;
  localparam int CL = 6; // CAS latency fed in
  localparam int PIPE = 1; // Fixed flop stage between the hold tap and the issued command
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic writeActive = 1'b0;
  logic cke, csN, rasN, casN, weN, dqOeN, dqsOeN, mprBusy;
  logic [2:0] bankAddr;
  logic [15:0] addrBus, dqOut;
  logic [4:0] al, cas_write_latency, rl, wl;
  sdram_mode_pkg::burst_mode_t burstMode = sdram_mode_pkg::BURST_FIXED8;
  sdram_mode_pkg::mode_cfg_t modeCfg;
  sdram_mode_pkg::term_t term;
  sdram_mode_pkg::cmd_t iCmd;
  int errorCnt = 0;
  int nChecks = 0;
  always #5 clk = ~clk;
  sdram_ctrl_model ctl (.clk(clk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
    .weN(weN), .bankAddr(bankAddr), .addrBus(addrBus));
  sdram_mode_config_mpr dut (.clk(clk), .sys_rst(sys_rst), .cke(cke), .csN(csN),
    .rasN(rasN), .casN(casN), .weN(weN), .bankAddr(bankAddr), .addrBus(addrBus),
    .casLatency(5'(CL)), .burstMode(burstMode), .writeActive(writeActive), .modeCfg(modeCfg),
    .additiveLatency(al), .casWriteLatency(cas_write_latency), .readLatency(rl), .writeLatency(wl),
    .termApplied(term), .internalCmd(iCmd), .dqOut(dqOut), .dqOeN(dqOeN), .dqsOeN(dqsOeN),
    .mprBusy(mprBusy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrapUp();
    $display("checks %0d errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrapUp
  // One readout, judged beat by beat at the fixed read latency
  task automatic rd_chk(input logic [15:0] a, input int lat, input int nb, input int st,
      input logic [7:0] pat, input logic off);
    int n;
    ctl.send(3'h5, 3'h6, a);
    for (n = 0; n < 40 && iCmd.valid !== 1'b1; n++) ctl.tick();
    chk(n, lat + PIPE);
    chk({iCmd.toMpr, iCmd.autoPre}, 2'h2);
    repeat (CL) ctl.tick();
    chk(mprBusy, 1'b1);
    for (int k = 0; k < nb; k++) begin
      chk({dqOeN, dqsOeN}, {2{off}});
      if (!off) chk(dqOut, {16{pat[st + k]}});
      ctl.tick();
    end
    chk(dqOeN, 1'b1);
    repeat (2) ctl.tick();
    chk(mprBusy, 1'b0);
  endtask : rd_chk
  task automatic t_reset();
    chk(modeCfg, '0);
    chk({term, dqOeN, dqsOeN, mprBusy}, 7'h06);
    $display("reset test done");
  endtask : t_reset
  // Every additive latency code, impedance bits alternating
  task automatic t_latency();
    int exp[4] = '{0, CL - 1, CL - 2, 0};
    for (int c = 0; c < 4; c++) begin
      ctl.send(3'h0, 3'h1, 16'(c << 3) | (c[0] ? 16'h0020 : 16'h0002));
      chk(modeCfg.driverImpedance, c[0] ? 2'h2 : 2'h1);
      chk(al, exp[c]);
      chk(rl, exp[c] + CL);
    end
    $display("latency test done");
  endtask : t_latency
  // Write latency, dynamic termination, leveling, refused selects
  task automatic t_write();
    sdram_mode_pkg::mode_cfg_t keep;
    ctl.send(3'h0, 3'h2, 16'h04D8);
    chk({modeCfg.autoSelfRefresh, modeCfg.selfRefreshTemp}, 2'h3);
    chk(cas_write_latency, 5'h08);
    chk(wl, 5'h08);
    writeActive = 1'b1;
    ctl.tick();
    chk(term, 4'hA);
    ctl.send(3'h0, 3'h1, 16'h0084);
    ctl.tick();
    chk(term, 4'h1);
    writeActive = 1'b0;
    keep = modeCfg;
    ctl.send(3'h0, 3'h0, 16'hFFFF);
    ctl.send(3'h0, 3'h4, 16'hFFFF);
    chk(modeCfg, keep);
    $display("write test done");
  endtask : t_write
  // Write held for the additive latency, not redirected while readout is off
  task automatic t_hold();
    int n;
    ctl.send(3'h0, 3'h1, 16'h0008);
    ctl.send(3'h4, 3'h3, 16'h0400);
    for (n = 0; n < 40 && iCmd.valid !== 1'b1; n++) ctl.tick();
    chk(n, CL - 1 + PIPE);
    chk({iCmd.isRead, iCmd.toMpr}, 2'h0);
    $display("hold test done");
  endtask : t_hold
  // Readout orders, chop modes, reserved place, outputs off
  task automatic t_mpr();
    ctl.send(3'h0, 3'h1, 16'h0000);
    ctl.send(3'h0, 3'h3, 16'h0004);
    rd_chk(16'h0400, 0, 8, 0, 8'hAA, 1'b0);
    burstMode = sdram_mode_pkg::BURST_FIXED4;
    rd_chk(16'h0004, 0, 4, 4, 8'hAA, 1'b0);
    burstMode = sdram_mode_pkg::BURST_ON_FLY;
    rd_chk(16'h1000, 0, 8, 0, 8'hAA, 1'b0);
    rd_chk(16'h0000, 0, 4, 0, 8'hAA, 1'b0);
    ctl.send(3'h0, 3'h3, 16'h0000);
    ctl.send(3'h0, 3'h1, 16'h0010);
    ctl.send(3'h0, 3'h3, 16'h0005);
    rd_chk(16'h0000, CL - 2, 4, 0, 8'h00, 1'b0);
    ctl.send(3'h0, 3'h3, 16'h0000);
    ctl.send(3'h0, 3'h1, 16'h1000);
    ctl.send(3'h0, 3'h3, 16'h0004);
    rd_chk(16'h1000, 0, 8, 0, 8'hAA, 1'b1);
    ctl.send(3'h0, 3'h3, 16'h0000);
    $display("readout test done");
  endtask : t_mpr
  // Reset while a readout burst is on the lanes, then a plain array read
  task automatic t_rst_mpr();
    int n;
    ctl.send(3'h0, 3'h1, 16'h0000);
    ctl.send(3'h0, 3'h3, 16'h0004);
    ctl.send(3'h5, 3'h0, 16'h0000);
    repeat (CL + 2) ctl.tick();
    chk({mprBusy, dqOeN}, 2'h2);
    sys_rst = 1'b1;
    ctl.tick();
    chk({mprBusy, dqOeN, modeCfg}, 32'h0008_0000);
    chk(iCmd, '0);
    sys_rst = 1'b0;
    ctl.tick();
    ctl.send(3'h5, 3'h0, 16'h0000);
    for (n = 0; n < 40 && iCmd.valid !== 1'b1; n++) ctl.tick();
    chk(n, PIPE);
    chk({iCmd.isRead, iCmd.toMpr}, 2'h2);
    repeat (CL + 2) ctl.tick();
    chk({mprBusy, dqOeN}, 2'h1);
    $display("reset in readout test done");
  endtask : t_rst_mpr
  initial begin
    repeat (16) @(posedge clk);
    #1;
    t_reset();
    sys_rst = 1'b0;
    ctl.tick();
    t_latency();
    t_write();
    t_hold();
    t_mpr();
    t_rst_mpr();
    wrapUp();
  end
  // Hang guard, far beyond the expected run
  initial begin
    #200000;
    errorCnt++;
    wrapUp();
  end
endmodule : sdram_mode_config_mpr_tb
